/* logic/atsd_pkg.sv */
// package: register map, reset values and swap timing constants of the trim and swap delay bank
package atsd_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_REFERENCE_TRIM     = 10'h07c;
  localparam logic [9:0] IDX_TERMINATION_TRIM_A = 10'h07e;
  localparam logic [9:0] IDX_TERMINATION_TRIM_B = 10'h07f;
  localparam logic [9:0] IDX_TERMINATION_TRIM_C = 10'h080;
  localparam logic [9:0] IDX_TERMINATION_TRIM_D = 10'h081;
  localparam logic [9:0] IDX_SWAP_OVERLAP_DELAY = 10'h09a;
  localparam logic [9:0] IDX_STEER_SELECT_DELAY = 10'h09b;
  localparam logic [9:0] IDX_SWAP_STATUS        = 10'h0f0;
  // field layout
  localparam int          REF_TRIM_W            = 4;
  localparam int          TERM_TRIM_W           = 8;
  localparam int          DELAY_W               = 5;
  localparam int          STATUS_BUSY_BIT       = 0;
  localparam int          STATUS_CORE_BIT       = 1;
  // reset values
  localparam logic [3:0]  REFERENCE_TRIM_RESET  = 4'h0;
  localparam logic [7:0]  TERMINATION_RESET     = 8'h00;
  localparam logic [4:0]  SWAP_OVERLAP_RESET    = 5'h08;
  localparam logic [4:0]  STEER_SELECT_RESET    = 5'h07;
  // overlap length is base plus twice the programmed delay, in converter cycles
  localparam logic [6:0]  OVERLAP_BASE          = 7'h04;
  // bus answers
  localparam logic [1:0]  RESP_OKAY             = 2'h0;
  localparam logic [1:0]  RESP_SLVERR           = 2'h2;
  // trim bank write selects
  localparam logic [2:0]  SEL_REFERENCE         = 3'h0;

  typedef enum logic [3:0] {
    REG_NONE      = 4'h0,
    REG_REFERENCE = 4'h1,
    REG_TERM_A    = 4'h2,
    REG_TERM_B    = 4'h3,
    REG_TERM_C    = 4'h4,
    REG_TERM_D    = 4'h5,
    REG_OVERLAP   = 4'h6,
    REG_STEER     = 4'h7,
    REG_STATUS    = 4'h8
  } atsd_reg_type;

  typedef enum logic [0:0] {
    SWAP_IDLE = 1'b0,
    SWAP_RUN  = 1'b1
  } atsd_swap_state_type;
endpackage : atsd_pkg

/* logic/atsd_swap_if.sv */
// interface: delay settings and swap control between the register bank and the swap sequencer
interface atsd_swap_if;
  logic [4:0] overlap_delay;
  logic [4:0] steer_delay;
  logic       start;
  logic       tick;
  logic       overlap_active;
  logic       core_select;
  logic       active_core;
  logic       busy;

  modport ctrl (
    output overlap_delay, steer_delay, start, tick,
    input  overlap_active, core_select, active_core, busy
  );
  modport seq (
    input  overlap_delay, steer_delay, start, tick,
    output overlap_active, core_select, active_core, busy
  );
endinterface : atsd_swap_if

/* logic/atsd_trim_bank.sv */
// trim bank: reference and termination trims, cleared by reset and then loaded with factory values
module atsd_trim_bank #(
  parameter int NUM_INPUTS = 4
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // factory values
  input  wire logic [3:0]                 factory_reference,
  input  wire logic [NUM_INPUTS-1:0][7:0] factory_termination,
  // software write port
  input  wire logic                       wr_en,
  input  wire logic [2:0]                 wr_sel,
  input  wire logic [7:0]                 wr_data,
  // trims
  output logic      [3:0]                 reference_trim,
  output logic      [NUM_INPUTS-1:0][7:0] termination_trim,
  output logic                            load_pending
);
  if (NUM_INPUTS < 1 || NUM_INPUTS > 7) begin : g_check
    $error("atsd_trim_bank: NUM_INPUTS must be 1 to 7");
  end

  typedef struct packed {
    logic                       pending;
    logic [3:0]                 ref_trim;
    logic [NUM_INPUTS-1:0][7:0] term;
  } atsd_trim_state_type;

  atsd_trim_state_type s_reg;
  atsd_trim_state_type s_next;

  always_comb begin
    s_next = s_reg;
    // factory load happens once, on the first edge after reset release
    if (s_reg.pending) begin
      s_next.pending  = 1'b0;
      s_next.ref_trim = factory_reference;
      s_next.term     = factory_termination;
    end else if (wr_en) begin
      if (wr_sel == atsd_pkg::SEL_REFERENCE) begin
        s_next.ref_trim = wr_data[3:0];
      end
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (wr_sel == 3'(i + 1)) begin
          s_next.term[i] = wr_data;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg.pending  <= 1'b1;
      s_reg.ref_trim <= atsd_pkg::REFERENCE_TRIM_RESET;
      s_reg.term     <= {NUM_INPUTS{atsd_pkg::TERMINATION_RESET}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign reference_trim   = s_reg.ref_trim;
  assign termination_trim = s_reg.term;
  assign load_pending     = s_reg.pending;
endmodule : atsd_trim_bank

/* logic/atsd_swap_seq.sv */
// swap sequencer: overlap window and delayed output steering during a background core swap
module atsd_swap_seq (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // settings and status
  atsd_swap_if.seq  sw
);
  typedef struct packed {
    atsd_pkg::atsd_swap_state_type state;
    logic [6:0]                    overlap_cnt;
    logic [4:0]                    steer_cnt;
    logic                          steered;
    logic                          overlap_active;
    logic                          active_core;
    logic                          core_select;
  } atsd_seq_state_type;

  atsd_seq_state_type s_reg;
  atsd_seq_state_type s_next;

  always_comb begin
    s_next = s_reg;
    case (s_reg.state)
      atsd_pkg::SWAP_IDLE: begin
        if (sw.start) begin
          // settings are captured here, so a late register write cannot disturb a running swap
          s_next.state          = atsd_pkg::SWAP_RUN;
          s_next.overlap_cnt    = atsd_pkg::OVERLAP_BASE + {1'b0, sw.overlap_delay, 1'b0};
          s_next.overlap_active = 1'b1;
          s_next.steer_cnt      = sw.steer_delay;
          s_next.steered        = (sw.steer_delay == 5'h00);
        end
      end
      atsd_pkg::SWAP_RUN: begin
        if (sw.tick) begin
          if (s_reg.overlap_cnt != 7'h00) begin
            s_next.overlap_cnt    = s_reg.overlap_cnt - 7'h01;
            s_next.overlap_active = (s_reg.overlap_cnt != 7'h01);
          end
          if (s_reg.steer_cnt != 5'h00) begin
            s_next.steer_cnt = s_reg.steer_cnt - 5'h01;
            s_next.steered   = (s_reg.steer_cnt == 5'h01);
          end
        end
        if (s_reg.overlap_cnt == 7'h00 && s_reg.steered) begin
          s_next.state       = atsd_pkg::SWAP_IDLE;
          s_next.active_core = ~s_reg.active_core;
          s_next.steered     = 1'b0;
        end
      end
      default: begin
        s_next.state = atsd_pkg::SWAP_IDLE;
      end
    endcase
    // outside a swap the steering follows the active core only
    s_next.core_select = s_next.active_core ^ (s_next.state == atsd_pkg::SWAP_RUN && s_next.steered);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sw.overlap_active = s_reg.overlap_active;
  assign sw.core_select    = s_reg.core_select;
  assign sw.active_core    = s_reg.active_core;
  assign sw.busy           = (s_reg.state == atsd_pkg::SWAP_RUN);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_OVERLAP_LOAD: assert property ((s_reg.state == atsd_pkg::SWAP_IDLE) && sw.start
    |=> s_reg.overlap_active && s_reg.overlap_cnt == 7'(4 + 2 * $past(sw.overlap_delay)))
    else $error("overlap length not loaded as four plus twice the delay");
  AST_OVERLAP_END: assert property (s_reg.overlap_active && s_reg.overlap_cnt == 7'h01 && sw.tick
    |=> !s_reg.overlap_active ##0 s_reg.overlap_cnt == 7'h00)
    else $error("overlap window did not close on its last converter cycle");
  AST_STEER_IDLE: assert property (s_reg.state == atsd_pkg::SWAP_IDLE |-> s_reg.core_select == s_reg.active_core)
    else $error("steering moved outside a swap");
  AST_STEER_ZERO: assert property ((s_reg.state == atsd_pkg::SWAP_IDLE) && sw.start && sw.steer_delay == 5'h00
    |=> s_reg.core_select != s_reg.active_core)
    else $error("zero steer delay did not switch at swap start");
  AST_STEER_HOLD: assert property ((s_reg.state == atsd_pkg::SWAP_RUN) && !s_reg.steered
    |-> s_reg.core_select == s_reg.active_core)
    else $error("steering switched before the delayed select");
endmodule : atsd_swap_seq

/* logic/atsd_regs.sv */
// top: trim and swap delay register bank behind an axi4-lite slave
// Function
// - 4-bit reference trim in low bits, factory value after reset, readable and writable.
// - Four 8-bit termination trims, inputs a to d, at consecutive addresses.
// - Termination trims hold factory values after reset; reads return them, writes replace them.
// - Overlap delay is 5 bits, resets to 8, accepts 0 to 31.
// - During a swap both cores sample together for 4 plus twice the overlap delay.
// - Steer select delay is 5 bits, resets to 7, delays the core output select.
// - Steer select delay acts only during a swap; otherwise steering is unaffected.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module atsd_regs #(
  parameter int NUM_INPUTS = 4
) (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // axi4-lite write address
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [11:0]                s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  // axi4-lite write data
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  // axi4-lite write response
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic      [1:0]                 s_axi_bresp,
  // axi4-lite read address
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [11:0]                s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  // axi4-lite read data
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic      [31:0]                s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  // factory trim values
  input  wire logic [3:0]                 factory_reference_trim,
  input  wire logic [NUM_INPUTS-1:0][7:0] factory_termination_trim,
  // calibration engine
  input  wire logic                       swap_request,
  input  wire logic                       converter_tick,
  // analog trims
  output logic      [3:0]                 reference_trim,
  output logic      [NUM_INPUTS-1:0][7:0] termination_trim,
  // swap steering
  output logic                            overlap_active,
  output logic                            encoder_core_select,
  output logic                            swap_busy
);
  if (NUM_INPUTS != 4) begin : g_check
    $error("atsd_regs: the register map holds exactly four termination trims");
  end

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic        aw_full;
    logic        w_full;
    logic [9:0]  aw_idx;
    logic [7:0]  wdata;
    logic        wlane;
    logic [4:0]  overlap_delay;
    logic [4:0]  steer_delay;
  } atsd_top_state_type;

  atsd_top_state_type s_reg;
  atsd_top_state_type s_next;

  logic       trim_wr_en;
  logic [2:0] trim_wr_sel;
  logic       trim_load_pending;

  atsd_swap_if sw ();

  // one decoder shared by the read and write paths keeps the map in one place
  function automatic atsd_pkg::atsd_reg_type decode(input logic [9:0] idx);
    case (idx)
      atsd_pkg::IDX_REFERENCE_TRIM:     decode = atsd_pkg::REG_REFERENCE;
      atsd_pkg::IDX_TERMINATION_TRIM_A: decode = atsd_pkg::REG_TERM_A;
      atsd_pkg::IDX_TERMINATION_TRIM_B: decode = atsd_pkg::REG_TERM_B;
      atsd_pkg::IDX_TERMINATION_TRIM_C: decode = atsd_pkg::REG_TERM_C;
      atsd_pkg::IDX_TERMINATION_TRIM_D: decode = atsd_pkg::REG_TERM_D;
      atsd_pkg::IDX_SWAP_OVERLAP_DELAY: decode = atsd_pkg::REG_OVERLAP;
      atsd_pkg::IDX_STEER_SELECT_DELAY: decode = atsd_pkg::REG_STEER;
      atsd_pkg::IDX_SWAP_STATUS:        decode = atsd_pkg::REG_STATUS;
      default:                          decode = atsd_pkg::REG_NONE;
    endcase
  endfunction : decode

  always_comb begin
    atsd_pkg::atsd_reg_type wr_reg;
    atsd_pkg::atsd_reg_type rd_reg;
    wr_reg      = decode(s_reg.aw_idx);
    rd_reg      = decode(s_axi_araddr[11:2]);
    s_next      = s_reg;
    trim_wr_en  = 1'b0;
    trim_wr_sel = atsd_pkg::SEL_REFERENCE;
    // address and data are caught independently, in either order
    if (s_reg.awready && s_axi_awvalid) begin
      s_next.aw_full = 1'b1;
      s_next.aw_idx  = s_axi_awaddr[11:2];
    end
    if (s_reg.wready && s_axi_wvalid) begin
      s_next.w_full = 1'b1;
      s_next.wdata  = s_axi_wdata[7:0];
      s_next.wlane  = s_axi_wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    // reserved bits are not stored; what software writes there is dropped
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = atsd_pkg::RESP_OKAY;
      case (wr_reg)
        atsd_pkg::REG_REFERENCE, atsd_pkg::REG_TERM_A, atsd_pkg::REG_TERM_B,
        atsd_pkg::REG_TERM_C, atsd_pkg::REG_TERM_D: begin
          trim_wr_en  = s_reg.wlane;
          trim_wr_sel = 3'(wr_reg - atsd_pkg::REG_REFERENCE);
        end
        atsd_pkg::REG_OVERLAP: begin
          if (s_reg.wlane) begin
            s_next.overlap_delay = s_reg.wdata[4:0];
          end
        end
        atsd_pkg::REG_STEER: begin
          if (s_reg.wlane) begin
            s_next.steer_delay = s_reg.wdata[4:0];
          end
        end
        atsd_pkg::REG_STATUS: begin
          s_next.bresp = atsd_pkg::RESP_OKAY;
        end
        default: begin
          s_next.bresp = atsd_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_reg.arready && s_axi_arvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = atsd_pkg::RESP_OKAY;
      case (rd_reg)
        atsd_pkg::REG_REFERENCE: s_next.rdata = {4'h0, reference_trim};
        atsd_pkg::REG_TERM_A:    s_next.rdata = termination_trim[0];
        atsd_pkg::REG_TERM_B:    s_next.rdata = termination_trim[1];
        atsd_pkg::REG_TERM_C:    s_next.rdata = termination_trim[2];
        atsd_pkg::REG_TERM_D:    s_next.rdata = termination_trim[3];
        atsd_pkg::REG_OVERLAP:   s_next.rdata = {3'h0, s_reg.overlap_delay};
        atsd_pkg::REG_STEER:     s_next.rdata = {3'h0, s_reg.steer_delay};
        atsd_pkg::REG_STATUS:    s_next.rdata = {6'h00, sw.active_core, sw.busy};
        default: begin
          s_next.rdata = 8'h00;
          s_next.rresp = atsd_pkg::RESP_SLVERR;
        end
      endcase
    end
    // ready is withheld while a channel is holding its item or an answer waits
    s_next.awready = !s_next.aw_full && !s_next.bvalid;
    s_next.wready  = !s_next.w_full && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg               <= '0;
      s_reg.overlap_delay <= atsd_pkg::SWAP_OVERLAP_RESET;
      s_reg.steer_delay   <= atsd_pkg::STEER_SELECT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  atsd_trim_bank #(
    .NUM_INPUTS (NUM_INPUTS)
  ) u_trim (
    .clk                 (aclk),
    .rst_n               (aresetn),
    .factory_reference   (factory_reference_trim),
    .factory_termination (factory_termination_trim),
    .wr_en               (trim_wr_en),
    .wr_sel              (trim_wr_sel),
    .wr_data             (s_reg.wdata),
    .reference_trim      (reference_trim),
    .termination_trim    (termination_trim),
    .load_pending        (trim_load_pending)
  );

  assign sw.overlap_delay = s_reg.overlap_delay;
  assign sw.steer_delay   = s_reg.steer_delay;
  assign sw.start         = swap_request;
  assign sw.tick          = converter_tick;

  atsd_swap_seq u_seq (
    .clk   (aclk),
    .rst_n (aresetn),
    .sw    (sw.seq)
  );

  assign s_axi_awready       = s_reg.awready;
  assign s_axi_wready        = s_reg.wready;
  assign s_axi_bvalid        = s_reg.bvalid;
  assign s_axi_bresp         = s_reg.bresp;
  assign s_axi_arready       = s_reg.arready;
  assign s_axi_rvalid        = s_reg.rvalid;
  assign s_axi_rresp         = s_reg.rresp;
  assign s_axi_rdata         = {24'h000000, s_reg.rdata};
  assign overlap_active      = sw.overlap_active;
  assign encoder_core_select = sw.core_select;
  assign swap_busy           = sw.busy;

  AST_OVERLAP_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> s_reg.overlap_delay == 5'h08)
    else $error("overlap delay did not reset to eight");
  AST_STEER_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> s_reg.steer_delay == 5'h07)
    else $error("steer delay did not reset to seven");
  AST_FACTORY_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |=> reference_trim == $past(factory_reference_trim)
      && termination_trim == $past(factory_termination_trim))
    else $error("factory trims not loaded after reset");
  AST_TERM_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    trim_wr_en && trim_wr_sel == 3'h3 && !trim_load_pending |=> termination_trim[2] == $past(s_reg.wdata))
    else $error("termination trim write not stored");
  AST_READ_UPPER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && $stable(s_axi_rdata) || $rose(s_axi_rvalid))
    else $error("read data above the byte not zero or changed while waiting");
  AST_REF_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    trim_wr_en && trim_wr_sel == atsd_pkg::SEL_REFERENCE && !trim_load_pending
      |=> reference_trim == $past(s_reg.wdata[3:0]))
    else $error("reference trim write not stored");
  // trims move only on a write or the factory load; a stray enable would detune an input
  AST_TRIM_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    !trim_wr_en && !trim_load_pending |=> $stable(reference_trim) && $stable(termination_trim))
    else $error("trim changed without a write");
  AST_OVERLAP_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_reg.aw_full && s_reg.w_full && !s_reg.bvalid && s_reg.wlane
      && decode(s_reg.aw_idx) == atsd_pkg::REG_OVERLAP |=> s_reg.overlap_delay == $past(s_reg.wdata[4:0]))
    else $error("overlap delay write not stored");
  AST_STEER_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_reg.aw_full && s_reg.w_full && !s_reg.bvalid && s_reg.wlane
      && decode(s_reg.aw_idx) == atsd_pkg::REG_STEER |=> s_reg.steer_delay == $past(s_reg.wdata[4:0]))
    else $error("steer delay write not stored");
endmodule : atsd_regs

/* bench/tb.sv */
// testbench: register access and swap timing of the trim and swap delay bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] FREF = 4'h9;
  logic            aclk;
  logic            aresetn;
  logic            awvalid, wvalid, bready, arvalid, rready, swap_request, tick;
  logic            awready, wready, bvalid, arready, rvalid, ovl, sel, busy;
  logic [11:0]     awaddr, araddr;
  logic [31:0]     wdata, rdata;
  logic [3:0]      wstrb, ref_trim;
  logic [1:0]      bresp, rresp;
  logic [3:0][7:0] term;
  logic [3:0][7:0] fterm;
  int              fails, samples_checked, cycles;

  atsd_regs #(.NUM_INPUTS(4)) i_atsd_regs (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .factory_reference_trim(FREF), .factory_termination_trim(fterm),
    .swap_request(swap_request), .converter_tick(tick),
    .reference_trim(ref_trim), .termination_trim(term),
    .overlap_active(ovl), .encoder_core_select(sel), .swap_busy(busy)
  );

  always #10 aclk = ~aclk;

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // write address and data offered together; each released at its own handshake
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk($sformatf("bresp %h", idx), {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk($sformatf("rdata %h", idx), e, rdata);
    chk($sformatf("rresp %h", idx), {30'h0, er}, {30'h0, rresp});
  endtask : rd

  // one swap; counts are in converter ticks, and slow runs converter_tick at half the clock rate
  task automatic swap(input logic [4:0] d, input logic [4:0] s, input logic slow);
    logic sel0;
    int   k, n_ovl, k_sel;
    sel0 = sel;
    wr(atsd_pkg::IDX_SWAP_OVERLAP_DELAY, {27'h0, d}, 4'hf, 2'h0);
    wr(atsd_pkg::IDX_STEER_SELECT_DELAY, {27'h0, s}, 4'hf, 2'h0);
    chk("select before swap", {31'h0, sel0}, {31'h0, sel});
    n_ovl = 0;
    k_sel = -1;
    k = 0;
    swap_request <= 1'b1;
    @(posedge aclk);
    swap_request <= 1'b0;
    do begin
      @(posedge aclk);
      if (ovl === 1'b1 && tick === 1'b1) n_ovl++;
      if (k_sel < 0 && sel !== sel0) k_sel = k;
      if (tick === 1'b1) k++;
      if (slow && busy === 1'b1) tick <= ~tick;
    end while (busy === 1'b1 && k < 200);
    tick <= 1'b1;
    chk("overlap cycles", 4 + 2 * d, n_ovl);
    chk("select switch cycle", {27'h0, s}, k_sel);
    chk("select after swap", {31'h0, ~sel0}, {31'h0, sel});
    chk("busy after swap", 32'h0, {31'h0, busy});
  endtask : swap

  // values after the first reset: factory trims and default delays
  task automatic reset_values;
    chk("reference_trim port", {28'h0, FREF}, {28'h0, ref_trim});
    rd(atsd_pkg::IDX_REFERENCE_TRIM, {28'h0, FREF}, 2'h0);
    for (int i = 0; i < 4; i++) begin
      rd(atsd_pkg::IDX_TERMINATION_TRIM_A + 10'(i), {24'h0, fterm[i]}, 2'h0);
    end
    rd(atsd_pkg::IDX_SWAP_OVERLAP_DELAY, 32'h08, 2'h0);
    rd(atsd_pkg::IDX_STEER_SELECT_DELAY, 32'h07, 2'h0);
  endtask : reset_values

  task automatic trim_access;
    wr(atsd_pkg::IDX_REFERENCE_TRIM, 32'h5, 4'hf, 2'h0);
    wr(atsd_pkg::IDX_REFERENCE_TRIM, 32'ha, 4'he, 2'h0);
    rd(atsd_pkg::IDX_REFERENCE_TRIM, 32'h5, 2'h0);
    chk("reference_trim port", 32'h5, {28'h0, ref_trim});
    // all four written before any read back, so aliasing between inputs shows
    for (int i = 0; i < 4; i++) begin
      wr(atsd_pkg::IDX_TERMINATION_TRIM_A + 10'(i), 32'h60 + i, 4'hf, 2'h0);
    end
    for (int i = 0; i < 4; i++) begin
      rd(atsd_pkg::IDX_TERMINATION_TRIM_A + 10'(i), 32'h60 + i, 2'h0);
      chk("termination_trim port", 32'h60 + i, {24'h0, term[i]});
    end
  endtask : trim_access

  task automatic delay_access;
    wr(atsd_pkg::IDX_SWAP_OVERLAP_DELAY, 32'h1f, 4'hf, 2'h0);
    rd(atsd_pkg::IDX_SWAP_OVERLAP_DELAY, 32'h1f, 2'h0);
    wr(atsd_pkg::IDX_STEER_SELECT_DELAY, 32'h1f, 4'hf, 2'h0);
    rd(atsd_pkg::IDX_STEER_SELECT_DELAY, 32'h1f, 2'h0);
  endtask : delay_access

  task automatic unmapped_access;
    rd(10'h3ff, 32'h0, 2'h2);
    wr(10'h001, 32'h1, 4'hf, 2'h2);
  endtask : unmapped_access

  // reset in mid-run: written trims fall back to factory values, delays to defaults
  task automatic mid_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("select after reset", 32'h0, {31'h0, sel});
    chk("termination_trim port", {24'h0, fterm[2]}, {24'h0, term[2]});
    rd(atsd_pkg::IDX_REFERENCE_TRIM, {28'h0, FREF}, 2'h0);
    rd(atsd_pkg::IDX_TERMINATION_TRIM_D, {24'h0, fterm[3]}, 2'h0);
    rd(atsd_pkg::IDX_SWAP_OVERLAP_DELAY, 32'h08, 2'h0);
    rd(atsd_pkg::IDX_STEER_SELECT_DELAY, 32'h07, 2'h0);
  endtask : mid_reset

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, swap_request} = '0;
    tick = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    fterm = {8'hd4, 8'hc3, 8'hb2, 8'ha1};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    reset_values();
    trim_access();
    delay_access();
    unmapped_access();
    swap(5'h00, 5'h01, 1'b0);
    swap(5'h03, 5'h00, 1'b0);
    swap(5'h00, 5'h09, 1'b0);
    swap(5'h07, 5'h03, 1'b1);
    mid_reset();
    finish_test();
  end
endmodule : tb
